// >>> design/ldm_consts.svh
// Timing counts and field positions for the LED display multiplexer
`ifndef LDM_CONSTS_SVH
`define LDM_CONSTS_SVH
`define LDM_CLK_MHZ        100
`define LDM_DIGIT_US       244
`define LDM_BLANK_US       6
`define LDM_FRAME_HZ       500
`define LDM_DIGIT_CYC      (`LDM_DIGIT_US * `LDM_CLK_MHZ)
`define LDM_BLANK_CYC      (`LDM_BLANK_US * `LDM_CLK_MHZ)
`define LDM_NUM_DIGITS     8
`define LDM_TB_DIV_NORMAL  1
`define LDM_TB_DIV_SLOW    4
`define LDM_SEG_DP_BIT     7
`endif

// >>> design/ldm_pkg.sv
// Types for the LED display multiplexer
package ldm_pkg;
  typedef enum logic [0:0] {
    LDM_ST_BLANK = 1'b0,
    LDM_ST_DRIVE = 1'b1
  } ldm_state_t;

  typedef struct packed {
    ldm_state_t  st;
    logic [1:0]  pre;
    logic [15:0] cnt;
    logic [2:0]  dig;
    logic [31:0] bcd;
    logic [2:0]  dp_pos;
    logic        ovf;
    logic [7:0]  seg;
    logic [7:0]  dsel;
  } ldm_reg_t;
endpackage : ldm_pkg

// >>> design/ldm_display_mux.sv
// Eight-digit seven-segment scan with blanking and leading-zero suppression
`timescale 1ns/1ps
`include "ldm_consts.svh"
// Function
// - Scan all eight digits at 500 Hz, each digit driven 244 us.
// - Insert a 6 us blank gap between one digit and the next.
// - Blank leading zeros until first nonzero digit or decimal point digit.
// - Digits below the decimal point always shown, zeros included.
// - Main counter overflow disables leading-zero blanking entirely.
// - Timebase divided by four slows frame to 125 Hz.
// - Overflow lights decimal point during the eighth digit slot.
// - Digit one carries the least significant digit.
// - Hold outside unit counting freezes the display latches.
module ldm_display_mux
  import ldm_pkg::*;
#(
  parameter int DIGIT_CYC = `LDM_DIGIT_CYC,
  parameter int BLANK_CYC = `LDM_BLANK_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        tb_div4_i,
  input  wire logic        result_valid_i,
  input  wire logic [31:0] result_bcd_i,
  input  wire logic [2:0]  result_dp_pos_i,
  input  wire logic        result_ovf_i,
  input  wire logic        hold_i,
  input  wire logic        unit_mode_i,
  output logic      [7:0]  seg_o,
  output logic      [7:0]  digit_sel_o,
  output logic             most_significant_digit_select_o,
  output logic             least_significant_digit_select_o
);

  ldm_reg_t q, d;

  function automatic logic [6:0] ldm_decode(input logic [3:0] v);
    unique case (v)
      4'h0: ldm_decode = 7'h3f;
      4'h1: ldm_decode = 7'h06;
      4'h2: ldm_decode = 7'h5b;
      4'h3: ldm_decode = 7'h4f;
      4'h4: ldm_decode = 7'h66;
      4'h5: ldm_decode = 7'h6d;
      4'h6: ldm_decode = 7'h7d;
      4'h7: ldm_decode = 7'h07;
      4'h8: ldm_decode = 7'h7f;
      4'h9: ldm_decode = 7'h6f;
      default: ldm_decode = 7'h00;
    endcase
  endfunction : ldm_decode

  // True when digit k is a leading zero to be blanked
  function automatic logic ldm_blank_zero(input logic [31:0] b, input logic [2:0] dp,
                                          input logic ov, input logic [2:0] k);
    logic z;
    z = 1'b1;
    if (ov || k <= dp) begin
      z = 1'b0;
    end
    for (int i = 0; i < `LDM_NUM_DIGITS; i++) begin
      if (i >= int'(k) && b[i*4 +: 4] != 4'h0) begin
        z = 1'b0;
      end
    end
    return z;
  endfunction : ldm_blank_zero

  logic [1:0]  pre_max;
  logic        tick;
  logic [3:0]  nib;
  logic [6:0]  glyph;
  logic        dp_on;

  always_comb begin
    d       = q;
    pre_max = tb_div4_i ? 2'(`LDM_TB_DIV_SLOW - 1) : 2'(`LDM_TB_DIV_NORMAL - 1);
    tick    = (q.pre >= pre_max);
    d.pre   = tick ? 2'h0 : q.pre + 2'h1;
    if (result_valid_i && !(hold_i && !unit_mode_i)) begin
      d.bcd    = result_bcd_i;
      d.dp_pos = result_dp_pos_i;
      d.ovf    = result_ovf_i;
    end
    nib   = q.bcd[q.dig*4 +: 4];
    glyph = ldm_blank_zero(q.bcd, q.dp_pos, q.ovf, q.dig) ? 7'h00 : ldm_decode(nib);
    dp_on = (q.dig == q.dp_pos && q.dp_pos != 3'h0) ||
            (q.dig == 3'(`LDM_NUM_DIGITS - 1) && q.ovf);
    if (tick) begin
      unique case (q.st)
        LDM_ST_BLANK: begin
          if (q.cnt >= 16'(BLANK_CYC - 1)) begin
            d.cnt  = 16'h0;
            d.st   = LDM_ST_DRIVE;
            d.seg  = {dp_on, glyph};
            d.dsel = 8'h01 << q.dig;
          end else begin
            d.cnt = q.cnt + 16'h1;
          end
        end
        LDM_ST_DRIVE: begin
          if (q.cnt >= 16'(DIGIT_CYC - 1)) begin
            d.cnt  = 16'h0;
            d.st   = LDM_ST_BLANK;
            d.seg  = 8'h00;
            d.dsel = 8'h00;
            d.dig  = q.dig + 3'h1;
          end else begin
            d.cnt = q.cnt + 16'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      seg_o                            <= 8'h00;
      digit_sel_o                      <= 8'h00;
      most_significant_digit_select_o  <= 1'b0;
      least_significant_digit_select_o <= 1'b0;
    end else begin
      seg_o                            <= d.seg;
      digit_sel_o                      <= d.dsel;
      most_significant_digit_select_o  <= d.dsel[7];
      least_significant_digit_select_o <= d.dsel[0];
    end
  end

endmodule : ldm_display_mux

// >>> testbench/ldm_checker.sv
// Scan timing checker
`timescale 1ns/1ps
module ldm_checker #(parameter int DIGIT_CYC = 20, parameter int BLANK_CYC = 4) (
  input wire logic clk_i, resetn_i, tb_div4_i,
  input wire logic [7:0] seg_o, digit_sel_o,
  input wire logic most_significant_digit_select_o, least_significant_digit_select_o);
  wire on = |digit_sel_o;
  logic [7:0] p_q;
  always_ff @(posedge clk_i, negedge resetn_i) begin
    if (!resetn_i) begin
      p_q <= 8'h80;
    end else if (on) begin
      p_q <= digit_sel_o;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  one_hot_a: assert property ($onehot0(digit_sel_o)) else $error("two on");
  blank_seg_a: assert property (!on |-> !seg_o) else $error("seg lit");
  no_swap_a: assert property (on && $past(on) |-> $stable(digit_sel_o))
    else $error("swap");
  digit_order_a: assert property ($rose(on) |-> digit_sel_o == {p_q[6:0], p_q[7]})
    else $error("order");
  gap_len_a: assert property ($fell(on) && !tb_div4_i |-> !on [*4] ##1 on)
    else $error("gap");
  drive_len_a: assert property ($rose(on) && !tb_div4_i |-> ##19 on ##1 !on)
    else $error("drive");
  slow_drive_a: assert property ($rose(on) && tb_div4_i |-> ##79 on ##1 !on)
    else $error("slow");
  slow_gap_a: assert property ($fell(on) && tb_div4_i |-> ##15 !on ##1 on)
    else $error("slow gap");
  msd_sel_a: assert property (most_significant_digit_select_o == digit_sel_o[7])
    else $error("msd select");
  lsd_sel_a: assert property (least_significant_digit_select_o == digit_sel_o[0])
    else $error("lsd select");
endmodule : ldm_checker
bind ldm_display_mux ldm_checker #(.DIGIT_CYC(DIGIT_CYC), .BLANK_CYC(BLANK_CYC)) u_chk (.*);

// >>> testbench/ldm_led_model.sv
// LED display model
`timescale 1ns/1ps
module ldm_led_model (input wire logic clk_i, input wire logic [7:0] seg_i, sel_i);
  logic [7:0] shown [8];
  always @(posedge clk_i) for (int i = 0; i < 8; i++) if (sel_i[i]) shown[i] <= seg_i;
endmodule : ldm_led_model

// >>> testbench/ldm_display_mux_tb.sv
// Display scan bench
`timescale 1ns/1ps
module ldm_display_mux_tb;
  logic clk_i = 0, resetn_i = 0, tb_div4_i = 0, result_valid_i = 0, result_ovf_i = 0;
  logic hold_i = 0, unit_mode_i = 0;
  logic most_significant_digit_select_o, least_significant_digit_select_o;
  logic [31:0] result_bcd_i = 0;
  logic [2:0] result_dp_pos_i = 0;
  logic [7:0] seg_o, digit_sel_o;
  int bad_count = 0, num_checks = 0, cyc = 0;
  always #5 clk_i = ~clk_i;
  ldm_display_mux #(.DIGIT_CYC(20), .BLANK_CYC(4)) u_ldm_display_mux (.*);
  ldm_led_model u_ldm_led_model (.clk_i(clk_i), .seg_i(seg_o), .sel_i(digit_sel_o));
  task automatic tally_and_finish();
    $display("checks %0d bad %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk_i) if (++cyc == 6000) begin bad_count++; tally_and_finish(); end
  task automatic run(input logic [31:0] v, input logic [2:0] p, input logic o, input int n,
      input logic [63:0] e);
    @(posedge clk_i);
    {result_bcd_i, result_dp_pos_i, result_ovf_i, result_valid_i} <= {v, p, o, 1'h1};
    @(posedge clk_i);
    result_valid_i <= 1'h0;
    repeat (n) @(posedge clk_i);
    for (int i = 0; i < 8; i++) if (u_ldm_led_model.shown[i] !== e[i*8+:8]) begin
      bad_count++;
      $display("mismatch %0t %h %h", $time, u_ldm_led_model.shown[i], e[i*8+:8]);
    end
    num_checks += 8;
    $display("done %0t", $time);
  endtask : run
  task automatic t_digits();
    run(32'h305, 3'h4, 1'h0, 400, 64'hbf3f4f3f6d);
    // Prescaled source moves the point one digit down; inputs kept in range
    run(32'h305, 3'h3, 1'h0, 400, 64'hbf4f3f6d);
  endtask : t_digits
  task automatic t_hold();
    run(32'h12, 3'h0, 1'h1, 400, 64'hbf3f3f3f3f3f065b);
    hold_i <= 1'h1;
    run(32'h8, 3'h0, 1'h0, 400, 64'hbf3f3f3f3f3f065b);
    unit_mode_i <= 1'h1;
    run(32'h8, 3'h0, 1'h0, 400, 64'h7f);
  endtask : t_hold
  task automatic t_slow();
    {resetn_i, tb_div4_i, hold_i, unit_mode_i} <= 4'h4;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'h1;
    run(32'h4, 3'h0, 1'h0, 1600, 64'h66);
  endtask : t_slow
  initial begin
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'h1;
    t_digits();
    t_hold();
    t_slow();
    tally_and_finish();
  end
endmodule : ldm_display_mux_tb
